// ===== irq_entry_pkg.sv
// constants, register map and state types for the port edge interrupt block
package irq_entry_pkg;
    // register indices; byte address is four times the index
    localparam logic [13:0] IDX_SRC_ENABLE = 14'h1001;
    localparam logic [13:0] IDX_SRC_STATUS = 14'h1002;
    localparam logic [13:0] IDX_PIN_MASK   = 14'h1011;
    localparam logic [13:0] IDX_POLARITY   = 14'h1012;
    localparam logic [13:0] IDX_PIN_STATUS = 14'h1013;

    localparam int PIN_COUNT    = 8;
    localparam int SRC_WIDTH    = 5;
    localparam int SRC_PORT_BIT = 2;
    localparam int PSW_IE_BIT   = 3;

    localparam logic [4:0]  RST_SRC_ENABLE = 5'h00;
    localparam logic [7:0]  RST_PIN_MASK   = 8'h00;
    localparam logic [7:0]  RST_POLARITY   = 8'h00;
    localparam logic [7:0]  RST_PIN_STATUS = 8'h00;
    localparam logic [7:0]  RST_PSW        = 8'h00;

    localparam logic [15:0] VEC_LO_ADDR = 16'h00fe;
    localparam logic [15:0] VEC_HI_ADDR = 16'h00ff;

    // synchroniser depth plus one sample of history before edges count
    localparam logic [1:0]  EDGE_ARM_CYCLES = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PUSH_PSW,
        ST_CLEAR_IE,
        ST_PUSH_PC_LO,
        ST_PUSH_PC_HI,
        ST_FETCH_LO,
        ST_FETCH_HI,
        ST_LOAD
    } entry_state_t;
endpackage

// ===== pin_edge_detect.sv
// per-pin synchroniser and selectable edge detector
`timescale 1ns/1ns
`default_nettype none
module pin_edge_detect #(
    parameter int WIDTH = 8
) (
    input  wire logic             mclk,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] pin,
    input  wire logic [WIDTH-1:0] polarity,
    output logic      [WIDTH-1:0] edge_hit
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
        logic [WIDTH-1:0] prev;
        logic [1:0]       arm;
    } edge_state_t;

    edge_state_t q;
    edge_state_t next_q;

    always_comb begin
        next_q      = q;
        next_q.meta = pin;
        next_q.sync = q.meta;
        next_q.prev = q.sync;
        // history is meaningless until the pipe has filled once
        if (q.arm != irq_entry_pkg::EDGE_ARM_CYCLES) begin
            next_q.arm = q.arm + 2'h1;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    for (genvar i = 0; i < WIDTH; i++) begin : g_pin
        logic armed;
        assign armed = (q.arm == irq_entry_pkg::EDGE_ARM_CYCLES);
        assign edge_hit[i] = armed & (polarity[i] ? (q.sync[i] & ~q.prev[i])
                                                  : (~q.sync[i] & q.prev[i]));

        a_edge_select:
        assert property (@(posedge mclk) disable iff (!arst_n)
            (armed && $past(polarity[i]) == polarity[i] && q.sync[i] != q.prev[i])
            |-> (edge_hit[i] == (q.sync[i] == polarity[i])))
        else $error("edge hit does not follow polarity");
    end
endmodule
`default_nettype wire

// ===== irq_entry_seq.sv
// single-vector interrupt entry sequence of the core
`timescale 1ns/1ns
`default_nettype none
module irq_entry_seq (
    input  wire logic        mclk,
    input  wire logic        arst_n,
    input  wire logic        irq_req,
    input  wire logic        set_irq_flag_instr,
    input  wire logic        psw_restore,
    input  wire logic [7:0]  psw_restore_data,
    input  wire logic [15:0] next_pc,
    input  wire logic [7:0]  mem_rdata,
    output logic      [7:0]  processor_status_word,
    output logic             stack_push,
    output logic      [7:0]  stack_data,
    output logic             mem_rd,
    output logic      [15:0] mem_addr,
    output logic             pc_load,
    output logic      [15:0] pc_value,
    output logic             entry_busy
);
    localparam int IE = irq_entry_pkg::PSW_IE_BIT;

    typedef struct packed {
        irq_entry_pkg::entry_state_t state;
        logic [7:0]  psw;
        logic [15:0] ret_pc;
        logic [7:0]  vec_lo;
        logic [7:0]  stack_data;
        logic [15:0] pc_value;
        logic        pc_load;
    } seq_state_t;

    seq_state_t q;
    seq_state_t next_q;

    always_comb begin
        next_q         = q;
        next_q.pc_load = 1'b0;
        case (q.state)
            irq_entry_pkg::ST_IDLE: begin
                if (irq_req && q.psw[IE]) begin
                    next_q.state      = irq_entry_pkg::ST_PUSH_PSW;
                    next_q.stack_data = q.psw;
                    next_q.ret_pc     = next_pc;
                end else if (psw_restore) begin
                    next_q.psw = psw_restore_data;
                end else if (set_irq_flag_instr) begin
                    next_q.psw[IE] = 1'b1;
                end
            end
            irq_entry_pkg::ST_PUSH_PSW: begin
                next_q.state = irq_entry_pkg::ST_CLEAR_IE;
            end
            irq_entry_pkg::ST_CLEAR_IE: begin
                next_q.psw[IE]    = 1'b0;
                next_q.stack_data = q.ret_pc[7:0];
                next_q.state      = irq_entry_pkg::ST_PUSH_PC_LO;
            end
            irq_entry_pkg::ST_PUSH_PC_LO: begin
                next_q.stack_data = q.ret_pc[15:8];
                next_q.state      = irq_entry_pkg::ST_PUSH_PC_HI;
            end
            irq_entry_pkg::ST_PUSH_PC_HI: begin
                next_q.state = irq_entry_pkg::ST_FETCH_LO;
            end
            irq_entry_pkg::ST_FETCH_LO: begin
                next_q.state = irq_entry_pkg::ST_FETCH_HI;
            end
            irq_entry_pkg::ST_FETCH_HI: begin
                next_q.vec_lo = mem_rdata;
                next_q.state  = irq_entry_pkg::ST_LOAD;
            end
            irq_entry_pkg::ST_LOAD: begin
                next_q.pc_value = {mem_rdata, q.vec_lo};
                next_q.pc_load  = 1'b1;
                next_q.state    = irq_entry_pkg::ST_IDLE;
            end
            default: begin
                next_q.state = irq_entry_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            q       <= '0;
            q.psw   <= irq_entry_pkg::RST_PSW;
            q.state <= irq_entry_pkg::ST_IDLE;
        end else begin
            q <= next_q;
        end
    end

    always_comb begin
        mem_addr = '0;
        if (q.state == irq_entry_pkg::ST_FETCH_LO) begin
            mem_addr = irq_entry_pkg::VEC_LO_ADDR;
        end else if (q.state == irq_entry_pkg::ST_FETCH_HI) begin
            mem_addr = irq_entry_pkg::VEC_HI_ADDR;
        end
    end

    assign mem_rd = (q.state == irq_entry_pkg::ST_FETCH_LO) || (q.state == irq_entry_pkg::ST_FETCH_HI);
    assign stack_push = (q.state == irq_entry_pkg::ST_PUSH_PSW) || (q.state == irq_entry_pkg::ST_PUSH_PC_LO)
                     || (q.state == irq_entry_pkg::ST_PUSH_PC_HI);
    assign stack_data            = q.stack_data;
    assign processor_status_word = q.psw;
    assign pc_load               = q.pc_load;
    assign pc_value              = q.pc_value;
    assign entry_busy            = (q.state != irq_entry_pkg::ST_IDLE);

    a_accept_gate:
    assert property (@(posedge mclk) disable iff (!arst_n)
        (q.state == irq_entry_pkg::ST_IDLE && !(irq_req && q.psw[IE]))
        |=> q.state == irq_entry_pkg::ST_IDLE)
    else $error("entry taken without request and flag");

    a_psw_first:
    assert property (@(posedge mclk) disable iff (!arst_n)
        (q.state == irq_entry_pkg::ST_IDLE && irq_req && q.psw[IE])
        |=> stack_push && stack_data == $past(q.psw) && q.psw[IE])
    else $error("status word not pushed first");

    a_flag_cleared:
    assert property (@(posedge mclk) disable iff (!arst_n)
        (q.state == irq_entry_pkg::ST_PUSH_PSW) |=> ##1 !q.psw[IE] ##1 stack_push)
    else $error("interrupt flag not cleared after status push");

    a_return_push:
    assert property (@(posedge mclk) disable iff (!arst_n)
        (q.state == irq_entry_pkg::ST_IDLE && irq_req && q.psw[IE])
        |=> ##2 (stack_push && stack_data == $past(next_pc[7:0], 3))
            ##1 (stack_push && stack_data == $past(next_pc[15:8], 4)))
    else $error("return address push wrong");

    a_vector_load:
    assert property (@(posedge mclk) disable iff (!arst_n)
        (q.state == irq_entry_pkg::ST_FETCH_LO && mem_addr == irq_entry_pkg::VEC_LO_ADDR)
        |=> (mem_addr == irq_entry_pkg::VEC_HI_ADDR)
            ##1 1'b1
            ##1 (pc_load && pc_value == {$past(mem_rdata), $past(mem_rdata, 2)}))
    else $error("vector not loaded from fixed locations");
endmodule
`default_nettype wire

// ===== port_edge_irq_entry.sv
// port edge interrupt registers, source gating and core interrupt entry
// Behaviour
// - each pin detects falling edge when polarity bit 0, rising edge when 1
// - a detected edge sets that pin's status flag; 0 means nothing pending
// - all sources share one entry; firmware finds the source from status registers
// - entry only when status word interrupt flag bit 3 and source enable set
// - on entry the core pushes its status word onto the stack first
// - then the core clears its interrupt flag to block re-entry
// - then the core pushes the next instruction address as return address
// - then the program counter loads the vector stored at locations fe and ff
// - writing 0 to a status bit clears it; writing 1 leaves it
// - pin mask bit 1 lets the pin raise an interrupt; 0 blocks it
// - top-level enable bit 2 gates the combined port source
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module port_edge_irq_entry #(
    parameter int PINS = irq_entry_pkg::PIN_COUNT
) (
    input  wire logic            mclk,
    input  wire logic            arst_n,
    // apb slave
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [15:0]     paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    // external event pins
    input  wire logic [PINS-1:0] port_pin_n,
    // core side
    input  wire logic            set_irq_flag_instr,
    input  wire logic            psw_restore,
    input  wire logic [7:0]      psw_restore_data,
    input  wire logic [15:0]     next_pc,
    input  wire logic [7:0]      mem_rdata,
    output logic      [7:0]      processor_status_word,
    output logic                 stack_push,
    output logic      [7:0]      stack_data,
    output logic                 mem_rd,
    output logic      [15:0]     mem_addr,
    output logic                 pc_load,
    output logic      [15:0]     pc_value,
    output logic                 entry_busy,
    output logic                 irq_req
);
    localparam int PB = irq_entry_pkg::SRC_PORT_BIT;

    typedef struct packed {
        logic [irq_entry_pkg::SRC_WIDTH-1:0] irq_source_enable;
        logic                                port_src_flag;
        logic [PINS-1:0]                     port_pin_mask;
        logic [PINS-1:0]                     port_edge_polarity;
        logic [PINS-1:0]                     port_edge_status;
        logic [31:0]                         rdata;
        logic                                bad_addr;
    } regs_state_t;

    regs_state_t q;
    regs_state_t next_q;

    logic [PINS-1:0] edge_hit;
    logic [13:0]     idx;
    logic            aligned;
    logic            setup;
    logic            access;
    logic            wr;
    logic            hit_enable;
    logic            hit_status;
    logic            hit_mask;
    logic            hit_pol;
    logic            hit_pstat;
    logic            mapped;
    logic [31:0]     rd_mux;

    pin_edge_detect #(
        .WIDTH (PINS)
    ) u_edge (
        .mclk     (mclk),
        .arst_n   (arst_n),
        .pin      (port_pin_n),
        .polarity (q.port_edge_polarity),
        .edge_hit (edge_hit)
    );

    // one shared request; the firmware walks the status registers to find why
    irq_entry_seq u_entry (
        .mclk                  (mclk),
        .arst_n                (arst_n),
        .irq_req               (irq_req),
        .set_irq_flag_instr    (set_irq_flag_instr),
        .psw_restore           (psw_restore),
        .psw_restore_data      (psw_restore_data),
        .next_pc               (next_pc),
        .mem_rdata             (mem_rdata),
        .processor_status_word (processor_status_word),
        .stack_push            (stack_push),
        .stack_data            (stack_data),
        .mem_rd                (mem_rd),
        .mem_addr              (mem_addr),
        .pc_load               (pc_load),
        .pc_value              (pc_value),
        .entry_busy            (entry_busy)
    );

    // address decode
    assign idx        = paddr[15:2];
    assign aligned    = (paddr[1:0] == 2'h0);
    assign hit_enable = aligned && (idx == irq_entry_pkg::IDX_SRC_ENABLE);
    assign hit_status = aligned && (idx == irq_entry_pkg::IDX_SRC_STATUS);
    assign hit_mask   = aligned && (idx == irq_entry_pkg::IDX_PIN_MASK);
    assign hit_pol    = aligned && (idx == irq_entry_pkg::IDX_POLARITY);
    assign hit_pstat  = aligned && (idx == irq_entry_pkg::IDX_PIN_STATUS);
    assign mapped     = hit_enable | hit_status | hit_mask | hit_pol | hit_pstat;

    assign setup  = psel && !penable;
    assign access = psel && penable;
    // q.bad_addr was taken from the same held address in the setup cycle
    assign wr     = access && pwrite && !q.bad_addr;

    always_comb begin
        rd_mux = '0;
        if (hit_enable) begin
            rd_mux[irq_entry_pkg::SRC_WIDTH-1:0] = q.irq_source_enable;
        end
        if (hit_status) begin
            rd_mux[PB] = q.port_src_flag;
        end
        if (hit_mask) begin
            rd_mux[PINS-1:0] = q.port_pin_mask;
        end
        if (hit_pol) begin
            rd_mux[PINS-1:0] = q.port_edge_polarity;
        end
        if (hit_pstat) begin
            rd_mux[PINS-1:0] = q.port_edge_status;
        end
    end

    always_comb begin
        next_q = q;
        // read data is caught in the setup cycle, so every access has zero waits
        if (setup) begin
            next_q.rdata    = rd_mux;
            next_q.bad_addr = !mapped;
        end
        if (wr && hit_enable) begin
            next_q.irq_source_enable = pwdata[irq_entry_pkg::SRC_WIDTH-1:0];
        end
        if (wr && hit_mask) begin
            next_q.port_pin_mask = pwdata[PINS-1:0];
        end
        if (wr && hit_pol) begin
            next_q.port_edge_polarity = pwdata[PINS-1:0];
        end
        // write 0 clears, write 1 keeps; a new edge in the same cycle wins
        if (wr && hit_pstat) begin
            next_q.port_edge_status = q.port_edge_status & pwdata[PINS-1:0];
        end
        next_q.port_edge_status = next_q.port_edge_status | edge_hit;
        if (wr && hit_status) begin
            next_q.port_src_flag = q.port_src_flag & pwdata[PB];
        end
        // while any unmasked pin flag stays set the top bit cannot be cleared
        if (|(q.port_edge_status & q.port_pin_mask)) begin
            next_q.port_src_flag = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            q                    <= '0;
            q.irq_source_enable  <= irq_entry_pkg::RST_SRC_ENABLE;
            q.port_pin_mask      <= irq_entry_pkg::RST_PIN_MASK;
            q.port_edge_polarity <= irq_entry_pkg::RST_POLARITY;
            q.port_edge_status   <= irq_entry_pkg::RST_PIN_STATUS;
        end else begin
            q <= next_q;
        end
    end

    // only the port source is built here; other top bits read as zero
    assign irq_req = q.port_src_flag && q.irq_source_enable[PB];

    assign prdata  = q.rdata;
    assign pready  = access;
    assign pslverr = access && q.bad_addr;

    a_status_set:
    assert property (@(posedge mclk) disable iff (!arst_n)
        (edge_hit != '0)
        |=> ((q.port_edge_status & $past(edge_hit)) == $past(edge_hit)))
    else $error("edge did not set its status flag");

    a_status_clear:
    assert property (@(posedge mclk) disable iff (!arst_n)
        (wr && hit_pstat)
        |=> (q.port_edge_status == (($past(q.port_edge_status) & $past(pwdata[PINS-1:0]))
                                    | $past(edge_hit))))
    else $error("status write did not clear by zeros only");

    a_top_set:
    assert property (@(posedge mclk) disable iff (!arst_n)
        (|(q.port_edge_status & q.port_pin_mask)) |=> q.port_src_flag)
    else $error("unmasked pin flag did not set top status");

    a_mask_block:
    assert property (@(posedge mclk) disable iff (!arst_n)
        (!q.port_src_flag && q.port_pin_mask == '0 && !(wr && hit_status))
        |=> !q.port_src_flag)
    else $error("masked pin raised top status");

    a_irq_hold:
    assert property (@(posedge mclk) disable iff (!arst_n)
        (irq_req && !(wr && (hit_status || hit_enable)))
        |=> irq_req)
    else $error("request dropped without firmware clear");

    a_irq_gate:
    assert property (@(posedge mclk) disable iff (!arst_n)
        (wr && hit_enable && !pwdata[PB]) |=> !irq_req)
    else $error("request with port source disabled");

    a_bad_addr:
    assert property (@(posedge mclk) disable iff (!arst_n)
        (setup && !mapped) |=> (access |-> pslverr))
    else $error("unmapped access not flagged");
endmodule
`default_nettype wire

// ===== pin_event_source.sv
// model of the external event sources that drive the port pins
`timescale 1ns/1ns
`default_nettype none
module pin_event_source #(
    parameter logic [7:0] INIT = 8'h0f
) (
    input  wire logic       mclk,
    input  wire logic       set_req,
    input  wire logic [7:0] set_level,
    output logic      [7:0] pins
);
    // sources are outside the device, so device reset leaves the levels alone
    initial pins = INIT;
    // a plain always, since the levels also get their start value from the initial above
    always @(posedge mclk) begin
        if (set_req) begin
            pins <= set_level;
        end
    end
endmodule
`default_nettype wire

// ===== test_port_edge_irq_entry.sv
// self-checking bench for the port edge interrupt block
`timescale 1ns/1ns
`default_nettype none
module test_port_edge_irq_entry;
    localparam logic [15:0] A_EN  = {irq_entry_pkg::IDX_SRC_ENABLE, 2'b00};
    localparam logic [15:0] A_TOP = {irq_entry_pkg::IDX_SRC_STATUS, 2'b00};
    localparam logic [15:0] A_MSK = {irq_entry_pkg::IDX_PIN_MASK, 2'b00};
    localparam logic [15:0] A_POL = {irq_entry_pkg::IDX_POLARITY, 2'b00};
    localparam logic [15:0] A_PST = {irq_entry_pkg::IDX_PIN_STATUS, 2'b00};
    logic        mclk = 1'b0;
    logic        arst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  port_pin_n;
    logic        pin_set = 1'b0;
    logic [7:0]  pin_level = 8'h0f;
    logic        set_irq_flag_instr = 1'b0;
    logic        psw_restore = 1'b0;
    logic [7:0]  psw_restore_data = 8'h00;
    logic [15:0] next_pc = 16'h0000;
    logic [7:0]  mem_rdata = 8'h00;
    logic [7:0]  processor_status_word;
    logic        stack_push;
    logic [7:0]  stack_data;
    logic        mem_rd;
    logic [15:0] mem_addr;
    logic        pc_load;
    logic [15:0] pc_value;
    logic        entry_busy;
    logic        irq_req;
    // vector stored before any interrupt is enabled
    logic [7:0]  vec_lo = 8'h34;
    logic [7:0]  vec_hi = 8'h12;
    logic [7:0]  pushes[$];
    logic [15:0] reads[$];
    int          n_errors = 0;
    int          cmp_count = 0;

    always #5 mclk = ~mclk;

    port_edge_irq_entry #(.PINS(8)) port_edge_irq_entry_i (
        .mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port_pin_n(port_pin_n), .set_irq_flag_instr(set_irq_flag_instr),
        .psw_restore(psw_restore), .psw_restore_data(psw_restore_data), .next_pc(next_pc),
        .mem_rdata(mem_rdata), .processor_status_word(processor_status_word),
        .stack_push(stack_push), .stack_data(stack_data), .mem_rd(mem_rd), .mem_addr(mem_addr),
        .pc_load(pc_load), .pc_value(pc_value), .entry_busy(entry_busy), .irq_req(irq_req));

    pin_event_source #(.INIT(8'h0f)) pin_event_source_i (
        .mclk(mclk), .set_req(pin_set), .set_level(pin_level), .pins(port_pin_n));

    // memory answers one cycle after the read; otherwise the bus keeps changing
    always @(posedge mclk) begin
        mem_rdata <= mem_rd ? ((mem_addr == irq_entry_pkg::VEC_LO_ADDR) ? vec_lo : vec_hi) : ~mem_rdata;
        if (stack_push === 1'b1) pushes.push_back(stack_data);
        if (mem_rd === 1'b1) reads.push_back(mem_addr);
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge mclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            n_errors++;
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic reg_wr(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic reg_chk(input logic [15:0] a, input logic [31:0] want);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, want);
    endtask

    // new levels land on the pins, then the sync pipe and flags settle
    task automatic drive_pins(input logic [7:0] lvl);
        @(posedge mclk);
        pin_set <= 1'b1;
        pin_level <= lvl;
        @(posedge mclk);
        pin_set <= 1'b0;
        repeat (7) @(posedge mclk);
    endtask

    task automatic wait_irq(input logic want);
        int n;
        for (n = 0; n < 20; n++) begin
            @(posedge mclk);
            if (irq_req === want) break;
        end
        check(irq_req, want);
        if (n == 20) begin
            n_errors++;
            wrap_up();
        end
    endtask

    task automatic t_regs;
        logic [31:0] r;
        logic        e;
        reg_chk(A_EN, {27'h0, irq_entry_pkg::RST_SRC_ENABLE});
        reg_chk(A_MSK, {24'h0, irq_entry_pkg::RST_PIN_MASK});
        reg_chk(A_POL, {24'h0, irq_entry_pkg::RST_POLARITY});
        reg_chk(A_PST, {24'h0, irq_entry_pkg::RST_PIN_STATUS});
        reg_wr(A_POL, 32'h0000_00a5);
        reg_chk(A_POL, 32'h0000_00a5);
        reg_wr(A_EN, 32'h0000_001b);
        reg_chk(A_EN, 32'h0000_001b);
        apb(1'b0, 16'h4000, 32'h0, r, e);
        check({31'h0, e}, 32'h1);
        check(r, 32'h0);
    endtask

    task automatic t_edges;
        reg_wr(A_POL, 32'h0000_000f);
        reg_wr(A_PST, 32'h0);
        drive_pins(8'hf0);
        reg_chk(A_PST, 32'h0);
        drive_pins(8'h0f);
        reg_chk(A_PST, 32'h0000_00ff);
        reg_wr(A_PST, 32'h0000_000f);
        reg_chk(A_PST, 32'h0000_000f);
        reg_wr(A_PST, 32'h0);
        reg_chk(A_PST, 32'h0);
    endtask

    task automatic t_gating;
        reg_wr(A_POL, 32'h0);
        reg_wr(A_PST, 32'h0);
        reg_wr(A_TOP, 32'h0);
        drive_pins(8'h0e);
        reg_chk(A_PST, 32'h0000_0001);
        reg_chk(A_TOP, 32'h0);
        reg_wr(A_MSK, 32'h0000_0001);
        reg_chk(A_TOP, 32'h0000_0004);
        check({31'h0, irq_req}, 32'h0);
        reg_wr(A_EN, 32'h0000_0004);
        wait_irq(1'b1);
        reg_wr(A_TOP, 32'h0);
        reg_chk(A_TOP, 32'h0000_0004);
    endtask

    task automatic t_entry;
        int n;
        // global flag still off: a pending request must not start an entry
        repeat (20) @(posedge mclk);
        check({31'h0, entry_busy}, 32'h0);
        next_pc <= 16'habcd;
        set_irq_flag_instr <= 1'b1;
        @(posedge mclk);
        set_irq_flag_instr <= 1'b0;
        for (n = 0; n < 30; n++) begin
            @(posedge mclk);
            if (pc_load === 1'b1) break;
        end
        if (n == 30) begin
            n_errors++;
            wrap_up();
        end
        check({16'h0, pc_value}, {16'h0, vec_hi, vec_lo});
        check({24'h0, processor_status_word}, 32'h0);
        check(pushes.size(), 3);
        check({24'h0, pushes[0]}, 32'h0000_0008);
        check({24'h0, pushes[1]}, 32'h0000_00cd);
        check({24'h0, pushes[2]}, 32'h0000_00ab);
        check({16'h0, reads[0]}, {16'h0, irq_entry_pkg::VEC_LO_ADDR});
        check({16'h0, reads[1]}, {16'h0, irq_entry_pkg::VEC_HI_ADDR});
        // request still pending, yet the cleared flag keeps it out
        repeat (20) @(posedge mclk);
        check({31'h0, entry_busy}, 32'h0);
        reg_wr(A_PST, 32'h0);
        reg_wr(A_TOP, 32'h0);
        wait_irq(1'b0);
        // return from interrupt restores the saved word; with nothing pending no entry follows
        psw_restore_data <= 8'h08;
        psw_restore <= 1'b1;
        @(posedge mclk);
        psw_restore <= 1'b0;
        @(posedge mclk);
        check({24'h0, processor_status_word}, 32'h0000_0008);
        repeat (5) @(posedge mclk);
        check({31'h0, entry_busy}, 32'h0);
    endtask

    initial begin
        repeat (10) @(posedge mclk);
        arst_n <= 1'b1;
        t_regs();
        t_edges();
        t_gating();
        t_entry();
        wrap_up();
    end
endmodule
`default_nettype wire
